//--- design/drive_parameter_bank.v
// drive parameter bank: fieldbus parameter registers and their effects
`timescale 1ns/1ps
`default_nettype none
`include "param_bank_defines.vh"
module drive_parameter_bank (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // power-on pulse: applies stored link settings
  input  wire        power_on,
  // parameter access from the protocol engines
  input  wire        par_wr,
  input  wire        par_rd,
  input  wire [15:0] par_addr,
  input  wire [15:0] par_wdata,
  output reg  [15:0] par_rdata,
  output reg         par_ack,
  output reg         par_err,
  // 32-bit word ordering for the protocol engines
  input  wire [31:0] dword_in,
  output reg  [31:0] serial_dword_out,
  output reg  [31:0] tcp_dword_out,
  // active serial link settings
  output reg  [15:0] active_bit_rate,
  output reg  [2:0]  active_data_bits,
  output reg         active_parity_en,
  output reg         active_parity_odd,
  output reg         active_two_stop,
  // link guard
  input  wire        link_activity,
  output wire        link_guard_fault,
  // synchronous error from mode control
  input  wire        sync_fault_flag,
  input  wire [15:0] sync_fault_in,
  // distance monitoring
  input  wire        reference_active,
  input  wire [15:0] follow_distance,
  output reg         distance_error,
  // power stage values and dc bus
  input  wire [15:0] bus_voltage,
  input  wire [15:0] bus_v_max_in,
  input  wire [15:0] bus_v_cutoff_in,
  input  wire [15:0] bus_v_halt_in,
  input  wire [15:0] temp_warn_in,
  input  wire [15:0] temp_limit_in,
  output reg         quick_stop,
  output reg         drive_off,
  // loop tuning reset
  output reg         loop_reset_pulse,
  // non-volatile store
  output reg         nv_save_req,
  input  wire        nv_save_done
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SAVE = 2'b10;

  reg [15:0] serial_bit_rate;
  reg [15:0] serial_frame_format;
  reg [15:0] link_guard_timeout;
  reg [15:0] serial_word_order;
  reg [15:0] tcp_word_order;
  reg [15:0] sync_fault_code;
  reg [15:0] max_follow_distance;
  reg [15:0] config_download_save;
  reg [15:0] loop_tuning_reset;
  reg [1:0]  save_state;
  reg [1:0]  next_save_state;
  reg        save_busy;
  reg        fault_d;
  reg        wr_ok;
  reg        rd_hit;
  reg [15:0] rd_val;

  function [31:0] order_words;
    input [31:0] dw;
    input [15:0] ord;
    begin
      if (ord == `ONE16)
        order_words = {dw[15:0], dw[31:16]};
      else
        order_words = dw;
    end
  endfunction

  // write range check
  always @* begin
    case (par_addr)
      `ADDR_BIT_RATE:
        wr_ok = (par_wdata == `RATE_9600) || (par_wdata == `RATE_19200)
             || (par_wdata == `RATE_38400);
      `ADDR_FRAME_FMT:
        wr_ok = (par_wdata >= `FMT_8N1) && (par_wdata <= `FMT_8N2);
      `ADDR_GUARD:      wr_ok = (par_wdata <= `GUARD_MAX);
      `ADDR_SER_ORDER:  wr_ok = (par_wdata <= `ORDER_MAX);
      `ADDR_TCP_ORDER:  wr_ok = (par_wdata <= `ORDER_MAX);
      `ADDR_MAX_DIST:   wr_ok = (par_wdata <= `DIST_MAX);
      `ADDR_LOOP_RESET: wr_ok = (par_wdata <= `ONE16);
      `ADDR_DL_SAVE:    wr_ok = (par_wdata <= `ONE16) && !save_busy;
      `ADDR_SAVE_CMD:   wr_ok = !save_busy;
      default:          wr_ok = 1'b0;
    endcase
  end

  // read decode
  always @* begin
    rd_hit = 1'b1;
    case (par_addr)
      `ADDR_SAVE_CMD:     rd_val = {`ZERO15, save_busy};
      `ADDR_LOOP_RESET:   rd_val = loop_tuning_reset;
      `ADDR_BUS_V_MAX:    rd_val = bus_v_max_in;
      `ADDR_BUS_V_CUTOFF: rd_val = bus_v_cutoff_in;
      `ADDR_TEMP_WARN:    rd_val = temp_warn_in;
      `ADDR_TEMP_LIMIT:   rd_val = temp_limit_in;
      `ADDR_BUS_V_HALT:   rd_val = bus_v_halt_in;
      `ADDR_BIT_RATE:     rd_val = serial_bit_rate;
      `ADDR_FRAME_FMT:    rd_val = serial_frame_format;
      `ADDR_GUARD:        rd_val = link_guard_timeout;
      `ADDR_SER_ORDER:    rd_val = serial_word_order;
      `ADDR_TCP_ORDER:    rd_val = tcp_word_order;
      `ADDR_FAULT_CODE:   rd_val = sync_fault_code;
      `ADDR_MAX_DIST:     rd_val = max_follow_distance;
      `ADDR_DL_SAVE:      rd_val = config_download_save;
      default: begin
        rd_hit = 1'b0;
        rd_val = `ZERO16;
      end
    endcase
  end

  // bus answer
  always @(posedge clk_sys) begin
    if (rst) begin
      par_rdata <= `ZERO16;
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
    end else begin
      par_ack <= par_wr || par_rd;
      par_err <= (par_wr && !wr_ok) || (par_rd && !par_wr && !rd_hit);
      if (par_rd && !par_wr)
        par_rdata <= rd_val;
    end
  end

  // stored parameters
  always @(posedge clk_sys) begin
    if (rst) begin
      serial_bit_rate      <= `RATE_19200;
      serial_frame_format  <= `FMT_8E1;
      link_guard_timeout   <= `ZERO16;
      serial_word_order    <= `ZERO16;
      tcp_word_order       <= `ZERO16;
      max_follow_distance  <= `DIST_DEFAULT;
      config_download_save <= `ZERO16;
      loop_tuning_reset    <= `ZERO16;
      loop_reset_pulse     <= 1'b0;
    end else begin
      loop_reset_pulse <= 1'b0;
      if (par_wr && wr_ok) begin
        case (par_addr)
          `ADDR_BIT_RATE:   serial_bit_rate     <= par_wdata;
          `ADDR_FRAME_FMT:  serial_frame_format <= par_wdata;
          `ADDR_GUARD:      link_guard_timeout  <= par_wdata;
          `ADDR_SER_ORDER:  serial_word_order   <= par_wdata;
          `ADDR_TCP_ORDER:  tcp_word_order      <= par_wdata;
          `ADDR_MAX_DIST:   max_follow_distance <= par_wdata;
          `ADDR_DL_SAVE:    config_download_save <= par_wdata;
          `ADDR_LOOP_RESET: begin
            loop_tuning_reset <= par_wdata;
            loop_reset_pulse  <= (par_wdata == `ONE16);
          end
          default: ;
        endcase
      end
    end
  end

  // active link settings, taken only at power-on
  always @(posedge clk_sys) begin
    if (rst) begin
      active_bit_rate   <= `RATE_19200;
      active_data_bits  <= `DATA_BITS_8;
      active_parity_en  <= 1'b1;
      active_parity_odd <= 1'b0;
      active_two_stop   <= 1'b0;
    end else if (power_on) begin
      active_bit_rate   <= serial_bit_rate;
      active_data_bits  <= `DATA_BITS_8;
      active_parity_en  <= (serial_frame_format == `FMT_8E1)
                        || (serial_frame_format == `FMT_8O1);
      active_parity_odd <= (serial_frame_format == `FMT_8O1);
      active_two_stop   <= (serial_frame_format == `FMT_8N2);
    end
  end

  // word ordering
  always @(posedge clk_sys) begin
    if (rst) begin
      serial_dword_out <= 32'h00000000;
      tcp_dword_out    <= 32'h00000000;
    end else begin
      serial_dword_out <= order_words(dword_in, serial_word_order);
      tcp_dword_out    <= order_words(dword_in, tcp_word_order);
    end
  end

  // fault code capture, monitors
  always @(posedge clk_sys) begin
    if (rst) begin
      sync_fault_code <= `ZERO16;
      fault_d         <= 1'b0;
      distance_error  <= 1'b0;
      quick_stop      <= 1'b0;
      drive_off       <= 1'b0;
    end else begin
      fault_d <= sync_fault_flag;
      if (sync_fault_flag && !fault_d)
        sync_fault_code <= sync_fault_in;
      distance_error <= reference_active && (max_follow_distance != `ZERO16)
                     && (follow_distance > max_follow_distance);
      quick_stop <= (bus_voltage <= bus_v_halt_in);
      drive_off  <= (bus_voltage <= bus_v_cutoff_in);
    end
  end

  // save sequencer
  always @* begin
    next_save_state = save_state;
    case (save_state)
      ST_IDLE: begin
        if (par_wr && wr_ok && ((par_addr == `ADDR_SAVE_CMD && par_wdata[`SAVE_BIT])
            || par_addr == `ADDR_DL_SAVE))
          next_save_state = ST_SAVE;
      end
      ST_SAVE: begin
        if (nv_save_done)
          next_save_state = ST_IDLE;
      end
      default: next_save_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      save_state  <= ST_IDLE;
      save_busy   <= 1'b0;
      nv_save_req <= 1'b0;
    end else begin
      save_state  <= next_save_state;
      save_busy   <= (next_save_state == ST_SAVE);
      nv_save_req <= (next_save_state == ST_SAVE);
    end
  end

  guard_timer u_guard (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .timeout_ms    (link_guard_timeout),
    .link_activity (link_activity),
    .guard_expired (link_guard_fault)
  );
endmodule // drive_parameter_bank
`default_nettype wire

//--- design/guard_timer.v
// link guard timer: counts milliseconds since last link activity
`timescale 1ns/1ps
`default_nettype none
`include "param_bank_defines.vh"
module guard_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // control
  input  wire [15:0] timeout_ms,
  input  wire        link_activity,
  // status
  output reg         guard_expired
);
  reg [`MS_CNT_W-1:0] cycle_cnt;
  reg [15:0]          ms_cnt;

  always @(posedge clk_sys) begin
    if (rst || link_activity || timeout_ms == `ZERO16) begin
      cycle_cnt     <= {`MS_CNT_W{1'b0}};
      ms_cnt        <= `ZERO16;
      guard_expired <= 1'b0;
    end else if (!guard_expired) begin
      if (cycle_cnt == `MS_CYCLES - 17'h00001) begin
        cycle_cnt <= {`MS_CNT_W{1'b0}};
        ms_cnt    <= ms_cnt + `ONE16;
        if (ms_cnt + `ONE16 >= timeout_ms)
          guard_expired <= 1'b1;
      end else begin
        cycle_cnt <= cycle_cnt + 17'h00001;
      end
    end
  end
endmodule // guard_timer
`default_nettype wire

//--- design/param_bank_defines.vh
// parameter addresses, limits and reset values of the drive parameter bank
`ifndef PARAM_BANK_DEFINES_VH
`define PARAM_BANK_DEFINES_VH

`define ADDR_SAVE_CMD        16'h0402
`define ADDR_LOOP_RESET      16'h040E
`define ADDR_BUS_V_MAX       16'h1006
`define ADDR_BUS_V_CUTOFF    16'h1008
`define ADDR_TEMP_WARN       16'h100C
`define ADDR_TEMP_LIMIT      16'h100E
`define ADDR_BUS_V_HALT      16'h1014
`define ADDR_BIT_RATE        16'h1606
`define ADDR_FRAME_FMT       16'h160A
`define ADDR_GUARD           16'h160C
`define ADDR_SER_ORDER       16'h160E
`define ADDR_TCP_ORDER       16'h190A
`define ADDR_FAULT_CODE      16'h1B32
`define ADDR_MAX_DIST        16'h2E06
`define ADDR_DL_SAVE         16'h3F5A

`define RATE_9600            16'h2580
`define RATE_19200           16'h4B00
`define RATE_38400           16'h9600
`define FMT_8N1              16'h0001
`define FMT_8E1              16'h0002
`define FMT_8O1              16'h0003
`define FMT_8N2              16'h0004
`define GUARD_MAX            16'h2710
`define DIST_MAX             16'h270F
`define DIST_DEFAULT         16'h0064
`define ORDER_MAX            16'h0001
`define ZERO16               16'h0000
`define ONE16                16'h0001
`define SAVE_BIT             0
`define DATA_BITS_8          3'h7
`define ZERO15               15'h0000
`define MS_CYCLES            17'h186A0
`define MS_CNT_W             17

`endif

//--- test/drive_parameter_bank_props.sv
// assertion checker for the drive parameter bank
`timescale 1ns/1ps
`default_nettype none
module drive_parameter_bank_props (
  // clock and reset
  input wire logic        clk_sys, rst,
  // parameter access
  input wire logic        par_wr, par_ack, par_err, power_on,
  input wire logic [15:0] par_addr, par_wdata, active_bit_rate,
  // save, tuning, monitors
  input wire logic        nv_save_req, nv_save_done, loop_reset_pulse,
  input wire logic        reference_active, distance_error, quick_stop, drive_off,
  input wire logic [15:0] bus_voltage, bus_v_halt_in, bus_v_cutoff_in
);
  logic loop_wr, qs_exp, off_exp;
  always @(posedge clk_sys) begin
    loop_wr <= par_wr && par_addr == 16'h040E && par_wdata == 16'h0001;
    qs_exp  <= bus_voltage <= bus_v_halt_in;
    off_exp <= bus_voltage <= bus_v_cutoff_in;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_save_cmd;
    par_wr && par_addr == 16'h0402 && par_wdata[0] && !nv_save_req;
  endsequence
  sequence s_save_end;
    nv_save_req && nv_save_done;
  endsequence
  a_ro_write_err: assert property (par_wr && par_addr == 16'h1006 |=> par_ack && par_err)
    else $error("read-only write not refused");
  a_rate_held: assert property (!power_on |=> $stable(active_bit_rate))
    else $error("bit rate changed without power-on");
  a_save_starts: assert property (s_save_cmd |=> nv_save_req)
    else $error("save not started");
  a_save_held: assert property (nv_save_req && !nv_save_done |=> nv_save_req)
    else $error("save dropped early");
  a_save_ends: assert property (s_save_end |=> !nv_save_req)
    else $error("save not ended");
  a_loop_pulse: assert property (loop_reset_pulse == loop_wr)
    else $error("tuning reset pulse wrong");
  a_dist_idle: assert property (!reference_active |=> !distance_error)
    else $error("distance error without reference");
  a_halt_level: assert property (!$past(rst) |-> quick_stop == qs_exp)
    else $error("quick stop wrong");
  a_cutoff_level: assert property (!$past(rst) |-> drive_off == off_exp)
    else $error("drive off wrong");
endmodule // drive_parameter_bank_props
bind drive_parameter_bank drive_parameter_bank_props u_props (.*);
`default_nettype wire

//--- test/nv_store_model.sv
// non-volatile store model answering save requests
`timescale 1ns/1ps
`default_nettype none
module nv_store_model #(
  parameter int DELAY = 5
) (
  input  wire logic clk_sys,
  input  wire logic nv_save_req,
  output logic      nv_save_done
);
  logic [7:0] cnt = 8'h00;
  // store busy for a fixed time, then one-cycle done
  always @(posedge clk_sys) begin
    if (!nv_save_req) cnt <= 8'h00;
    else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
  end
  assign nv_save_done = nv_save_req && (cnt == DELAY[7:0]);
endmodule // nv_store_model
`default_nettype wire

//--- test/test_drive_parameter_bank.sv
// testbench of the drive parameter bank
`timescale 1ns/1ps
`default_nettype none
module test_drive_parameter_bank;
  logic clk_sys, rst, power_on, par_wr, par_rd, sync_fault_flag, reference_active;
  logic par_ack, par_err, active_parity_en, active_parity_odd, active_two_stop;
  logic link_guard_fault, distance_error, quick_stop, drive_off, loop_reset_pulse;
  logic nv_save_req, nv_save_done, link_activity;
  logic [15:0] par_addr, par_wdata, par_rdata, follow_distance, bus_voltage;
  logic [15:0] sync_fault_in, active_bit_rate, bus_v_halt_in;
  logic [31:0] dword_in, serial_dword_out, tcp_dword_out;
  logic [2:0]  active_data_bits;
  wire logic [15:0] bus_v_max_in = 16'h0F00, temp_warn_in = 16'hFFF6;
  wire logic [15:0] temp_limit_in = 16'h0050, bus_v_cutoff_in = 16'h0150;
  int mismatches = 0, checks_done = 0, pulses = 0;
  typedef struct {logic w; logic [15:0] a, d; logic e; logic [15:0] r;} row_t;
  row_t rows[$] = '{'{0, 16'h1606, 0, 0, 16'h4B00}, '{0, 16'h160A, 0, 0, 16'h0002},
    '{0, 16'h2E06, 0, 0, 16'h0064}, '{0, 16'h1B32, 0, 0, 16'h0000},
    '{0, 16'h0402, 0, 0, 16'h0000}, '{0, 16'h1234, 0, 1, 16'h0000},
    '{0, 16'h100E, 0, 0, 16'h0050}, '{0, 16'h1008, 0, 0, 16'h0150},
    '{0, 16'h1014, 0, 0, 16'h0200}, '{1, 16'h1606, 16'h9600, 0, 16'h9600},
    '{1, 16'h1606, 16'h1234, 1, 16'h9600}, '{1, 16'h1606, 16'h2580, 0, 16'h2580},
    '{1, 16'h160A, 16'h0005, 1, 16'h0002}, '{1, 16'h160A, 16'h0004, 0, 16'h0004},
    '{1, 16'h160C, 16'h2711, 1, 16'h0000}, '{1, 16'h160C, 16'h2710, 0, 16'h2710},
    '{1, 16'h160E, 16'h0001, 0, 16'h0001}, '{1, 16'h190A, 16'h0002, 1, 16'h0000},
    '{1, 16'h190A, 16'h0001, 0, 16'h0001}, '{1, 16'h2E06, 16'h2710, 1, 16'h0064},
    '{1, 16'h2E06, 16'h270F, 0, 16'h270F}, '{1, 16'h1006, 16'h0001, 1, 16'h0F00},
    '{1, 16'h100C, 16'h0001, 1, 16'hFFF6}};

  drive_parameter_bank u_dut (.*);
  nv_store_model #(.DELAY(5)) u_nv (.clk_sys(clk_sys), .nv_save_req(nv_save_req),
    .nv_save_done(nv_save_done));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (loop_reset_pulse === 1'b1) pulses <= pulses + 1;

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle request, answer sampled after the taking edge
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(posedge clk_sys);
    par_wr <= w; par_rd <= !w; par_addr <= a; par_wdata <= d;
    @(posedge clk_sys);
    par_wr <= 1'b0; par_rd <= 1'b0;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 50 && nv_save_req !== 1'b0; k++) settle(1);
    chk("idle", 0, nv_save_req);
  endtask

  initial begin
    rst <= 1; power_on <= 0; par_wr <= 0; par_rd <= 0; par_addr <= 0; par_wdata <= 0;
    sync_fault_flag <= 0; sync_fault_in <= 0; reference_active <= 0; link_activity <= 0;
    follow_distance <= 0; bus_voltage <= 16'h0300; bus_v_halt_in <= 16'h0200;
    dword_in <= 32'h12345678;
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    settle(2);
    chk("ser", 32'h12345678, serial_dword_out);
    chk("tcp", 32'h12345678, tcp_dword_out);
    chk("guard", 0, link_guard_fault);
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      chk("err", rows[i].e, par_err);
      if (rows[i].w) acc(0, rows[i].a, 0);
      chk("rdata", rows[i].r, par_rdata);
    end
    settle(1);
    chk("ser", 32'h56781234, serial_dword_out);
    chk("tcp", 32'h56781234, tcp_dword_out);
    chk("rate", 16'h4B00, active_bit_rate);
    @(posedge clk_sys) power_on <= 1;
    @(posedge clk_sys) power_on <= 0;
    settle(2);
    chk("rate", 16'h2580, active_bit_rate);
    chk("fmt", 5'h1D, {active_data_bits, active_parity_en, active_two_stop});
    acc(1, 16'h0402, 16'h0001);
    chk("save", 1, nv_save_req);
    acc(1, 16'h3F5A, 16'h0001);
    chk("err", 1, par_err);
    acc(0, 16'h0402, 0);
    chk("busy", 1, par_rdata);
    wait_idle();
    acc(0, 16'h0402, 0);
    chk("done", 0, par_rdata);
    for (int v = 0; v < 2; v++) begin
      acc(1, 16'h3F5A, v[15:0]);
      chk("dlsave", 1, nv_save_req);
      wait_idle();
    end
    acc(1, 16'h040E, 16'h0001);
    acc(1, 16'h040E, 16'h0002);
    chk("err", 1, par_err);
    settle(2);
    chk("pulses", 1, pulses);
    @(posedge clk_sys) link_activity <= 1;
    @(posedge clk_sys) link_activity <= 0;
    settle(2);
    chk("guard", 0, link_guard_fault);
    @(posedge clk_sys) begin sync_fault_in <= 16'h00AB; sync_fault_flag <= 1; end
    @(posedge clk_sys) sync_fault_in <= 16'h0011;
    acc(0, 16'h1B32, 0);
    chk("code", 16'h00AB, par_rdata);
    @(posedge clk_sys) begin reference_active <= 1; follow_distance <= 16'h270F; end
    settle(3);
    chk("dist", 0, distance_error);
    @(posedge clk_sys) follow_distance <= 16'h2710;
    settle(3);
    chk("dist", 1, distance_error);
    acc(1, 16'h2E06, 16'h0000);
    settle(3);
    chk("dist", 0, distance_error);
    @(posedge clk_sys) bus_voltage <= 16'h0200;
    settle(3);
    chk("qstop", 1, quick_stop);
    chk("off", 0, drive_off);
    @(posedge clk_sys) begin bus_voltage <= 16'h0150; bus_v_halt_in <= 16'h0100; end
    settle(3);
    chk("qstop", 0, quick_stop);
    chk("off", 1, drive_off);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
endmodule // test_drive_parameter_bank
`default_nettype wire
